// file: bench/mcx_exec_tb_top.sv
// self-checking testbench for the execution unit
`timescale 1ns/10ps
`default_nettype none
module mcx_exec_tb_top;
  logic        i_core_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_op_valid = 1'b0;
  logic [4:0]  i_op = 5'h00;
  logic [4:0]  i_rd = 5'h00;
  logic [1:0]  i_ptr_sel = 2'h0;
  logic [1:0]  i_amode = 2'h0;
  logic [5:0]  i_disp = 6'h00;
  logic [15:0] i_imm = 16'h0000;
  logic [2:0]  i_bit = 3'h0;
  logic [7:0]  i_mem_rdata, o_mem_wdata, o_flags, wr_data, f0;
  logic        o_op_ready, o_mem_rd, o_mem_wr, o_sleep, slp;
  logic [15:0] o_mem_addr, o_pc, o_sp, rd_addr, wr_addr, pc0, busy;
  int          num_errors = 0;
  int          checks = 0;
  int          cycles = 0;
  always #25 i_core_clk = ~i_core_clk;
  mcx_exec u_dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_op_valid(i_op_valid), .i_op(i_op),
    .i_rd(i_rd), .i_ptr_sel(i_ptr_sel), .i_amode(i_amode), .i_disp(i_disp), .i_imm(i_imm),
    .i_bit(i_bit), .i_mem_rdata(i_mem_rdata), .o_op_ready(o_op_ready), .o_mem_rd(o_mem_rd),
    .o_mem_wr(o_mem_wr), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_sleep(o_sleep),
    .o_pc(o_pc), .o_flags(o_flags), .o_sp(o_sp));
  mcx_mem_model u_mem (.i_core_clk(i_core_clk), .i_mem_rd(o_mem_rd), .i_mem_wr(o_mem_wr),
    .i_mem_addr(o_mem_addr), .i_mem_wdata(o_mem_wdata), .o_mem_rdata(i_mem_rdata));
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      $display("ERROR at %0t: run did not finish", $time);
      finish_test();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // presents one op, waits until taken, then records strobes and stall cycles until ready
  task automatic issue(input mcx_pkg::mcx_op_e op, input logic [4:0] rd,
      input logic [15:0] imm = 16'h0000, input logic [1:0] ps = 2'h0,
      input logic [1:0] am = 2'h0, input logic [5:0] d = 6'h00, input logic [2:0] b = 3'h0);
    @(posedge i_core_clk);
    pc0 = o_pc;
    f0 = o_flags;
    busy = 16'h0000;
    slp = 1'b0;
    rd_addr = 16'hFFFF;
    wr_addr = 16'hFFFF;
    i_op_valid <= 1'b1;
    {i_op, i_rd, i_ptr_sel, i_amode, i_disp, i_imm, i_bit} <= {op, rd, ps, am, d, imm, b};
    @(negedge i_core_clk);
    while (o_op_ready !== 1'b1) @(negedge i_core_clk);
    @(posedge i_core_clk);
    i_op_valid <= 1'b0;
    for (int n = 0; n < 4; n++) begin
      @(negedge i_core_clk);
      slp = slp | o_sleep;
      if (o_mem_rd === 1'b1) rd_addr = o_mem_addr;
      if (o_mem_wr === 1'b1) begin
        wr_addr = o_mem_addr;
        wr_data = o_mem_wdata;
      end
      if (o_op_ready === 1'b1) break;
      busy++;
    end
  endtask
  task automatic jmp(input mcx_pkg::mcx_op_e op, input logic [6:0] k, input logic tk);
    issue(op, 5'h00, {9'h000, k});
    chk(o_pc, tk ? pc0 + {{9{k[6]}}, k} + 16'h0001 : pc0 + 16'h0001);
    chk(busy, {15'h0000, tk});
    chk({8'h00, o_flags}, {8'h00, f0});
  endtask
  logic [7:0] pinit [6] = '{8'h40, 8'h00, 8'h10, 8'h00, 8'h60, 8'h00};
  mcx_pkg::mcx_op_e fop [6] = '{mcx_pkg::OP_SETV, mcx_pkg::OP_CLRV, mcx_pkg::OP_SETH,
    mcx_pkg::OP_CLRH, mcx_pkg::OP_SETS, mcx_pkg::OP_CLRS};
  int fpos [3] = '{mcx_pkg::FLAG_V, mcx_pkg::FLAG_H, mcx_pkg::FLAG_S};
  initial begin
    repeat (12) @(posedge i_core_clk);
    chk(o_sp, mcx_pkg::SP_RESET);
    chk({o_flags, o_pc[7:0]}, 16'h0000);
    i_rst <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      issue(mcx_pkg::OP_DIR_LD, 5'(26 + k), {8'h00, pinit[k]});
      chk(rd_addr, {8'h00, pinit[k]});
      chk(busy, 16'h0001);
    end
    issue(mcx_pkg::OP_DIR_ST, 5'd26, 16'h0080);
    chk({wr_addr[7:0], wr_data}, 16'h8040);
    issue(mcx_pkg::OP_IND_LD, 5'd1, 16'h0000, mcx_pkg::PTR_X, mcx_pkg::AM_POSTINC);
    chk(rd_addr, 16'h0040);
    issue(mcx_pkg::OP_IND_ST, 5'd1, 16'h0000, mcx_pkg::PTR_X, mcx_pkg::AM_POSTINC);
    chk({wr_addr[7:0], wr_data}, 16'h4140);
    issue(mcx_pkg::OP_IND_LD, 5'd2, 16'h0000, mcx_pkg::PTR_X, mcx_pkg::AM_PREDEC);
    chk(rd_addr, 16'h0041);
    issue(mcx_pkg::OP_IND_ST, 5'd2, 16'h0000, mcx_pkg::PTR_X, mcx_pkg::AM_PREDEC);
    chk({wr_addr[7:0], wr_data}, 16'h4040);
    chk(busy, 16'h0001);
    $display("pointer test done");
    issue(mcx_pkg::OP_OFS_LD, 5'd3, 16'h0000, mcx_pkg::PTR_Y, mcx_pkg::AM_PLAIN, 6'h3F);
    chk(rd_addr, 16'h004F);
    issue(mcx_pkg::OP_OFS_ST, 5'd3, 16'h0000, mcx_pkg::PTR_Z, mcx_pkg::AM_PLAIN, 6'h05);
    chk({wr_addr[7:0], wr_data}, 16'h654F);
    issue(mcx_pkg::OP_IND_ST, 5'd3, 16'h0000, mcx_pkg::PTR_Y);
    chk(wr_addr, 16'h0010);
    issue(mcx_pkg::OP_IND_LD, 5'd5, 16'h0000, mcx_pkg::PTR_Z);
    chk(rd_addr, 16'h0060);
    issue(mcx_pkg::OP_PUSH, 5'd3);
    chk({wr_addr[7:0], wr_data}, 16'hDF4F);
    chk(o_sp, 16'h00DE);
    issue(mcx_pkg::OP_POP, 5'd6);
    chk(rd_addr, 16'h00DF);
    chk({o_sp[7:0], o_flags}, 16'hDF00);
    issue(mcx_pkg::OP_DIR_ST, 5'd6, 16'h0091);
    chk({8'h00, wr_data}, 16'h004F);
    issue(mcx_pkg::OP_IOSET, 5'd0, 16'h0020, 2'h0, 2'h0, 6'h00, 3'd3);
    chk({wr_addr[7:0], wr_data}, 16'h2028);
    issue(mcx_pkg::OP_IOCLR, 5'd0, 16'h0020, 2'h0, 2'h0, 6'h00, 3'd5);
    chk({wr_addr[7:0], wr_data}, 16'h2008);
    chk(busy, 16'h0001);
    $display("memory test done");
    issue(mcx_pkg::OP_DIR_LD, 5'd4, 16'h0081);
    issue(mcx_pkg::OP_ROL, 5'd4);
    chk({busy[7:0], o_flags & 8'h0F}, 16'h0009);
    issue(mcx_pkg::OP_ROR, 5'd4);
    chk({busy[7:0], o_flags & 8'h0F}, 16'h000C);
    issue(mcx_pkg::OP_TSTORE, 5'd4, 16'h0000, 2'h0, 2'h0, 6'h00, 3'd7);
    chk({8'h00, o_flags}, {8'h00, f0 | 8'h40});
    issue(mcx_pkg::OP_TLOAD, 5'd4, 16'h0000, 2'h0, 2'h0, 6'h00, 3'd1);
    chk({8'h00, o_flags}, {8'h00, f0});
    issue(mcx_pkg::OP_DIR_ST, 5'd4, 16'h0090);
    chk({8'h00, wr_data}, 16'h0083);
    issue(mcx_pkg::OP_TSTORE, 5'd4, 16'h0000, 2'h0, 2'h0, 6'h00, 3'd2);
    chk({8'h00, o_flags}, {8'h00, f0 & 8'hBF});
    $display("bit test done");
    // V is still set from the rotates, so clear it or the set step proves nothing
    issue(mcx_pkg::OP_CLRV, 5'd0);
    for (int k = 0; k < 6; k++) begin
      issue(fop[k], 5'd0);
      chk({8'h00, o_flags}, {8'h00, k[0] ? f0 & ~(8'h01 << fpos[k / 2])
                                          : f0 | (8'h01 << fpos[k / 2])});
    end
    $display("flag test done");
    jmp(mcx_pkg::OP_JMP_V1, 7'h05, 1'b0);
    jmp(mcx_pkg::OP_JMP_V0, 7'h05, 1'b1);
    issue(mcx_pkg::OP_SETV, 5'd0);
    jmp(mcx_pkg::OP_JMP_V1, 7'h7E, 1'b1);
    jmp(mcx_pkg::OP_JMP_V0, 7'h12, 1'b0);
    jmp(mcx_pkg::OP_JMP_I1, 7'h3F, 1'b0);
    jmp(mcx_pkg::OP_JMP_I0, 7'h3F, 1'b1);
    $display("jump test done");
    issue(mcx_pkg::OP_SLEEP, 5'd0);
    chk({7'h00, slp, o_flags}, {8'h01, f0});
    chk(busy, 16'h0000);
    $display("sleep test done");
    finish_test();
  end
endmodule
`default_nettype wire

// file: bench/mcx_mem_model.sv
// data memory and io space model facing the execution unit
`timescale 1ns/10ps
`default_nettype none
module mcx_mem_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_mem_rd,
  input  wire logic        i_mem_wr,
  input  wire logic [15:0] i_mem_addr,
  input  wire logic [7:0]  i_mem_wdata,
  output logic [7:0]       o_mem_rdata
);
  logic [7:0] mem [256];
  logic [7:0] last_q;
  // each byte starts equal to its own address so any read shows where it went
  initial begin
    last_q = 8'h00;
    for (int i = 0; i < 256; i++) mem[i] = i[7:0];
  end
  // a stale byte outside a read strobe would hide a late sample, so invert it
  assign o_mem_rdata = i_mem_rd ? mem[i_mem_addr[7:0]] : ~last_q;
  always @(posedge i_core_clk) begin
    if (i_mem_rd) last_q <= mem[i_mem_addr[7:0]];
    if (i_mem_wr) mem[i_mem_addr[7:0]] <= i_mem_wdata;
  end
endmodule
`default_nettype wire

// file: src/mcx_exec.sv
// execution unit for a subset of an 8-bit core's instruction set
// Summary of operation
// [RQ1] overflow jumps add offset plus one to pc when V matches; no flags change
// [RQ2] interrupt-state jumps add offset plus one to pc when I matches; no flags
// [RQ3] post-increment fetch reads byte at pointer into register, then pointer plus one
// [RQ4] pre-decrement fetch lowers pointer first, then reads byte at new address
// [RQ5] displaced fetch reads Y or Z plus displacement; pointer unchanged; two cycles
// [RQ6] direct fetch reads byte at immediate address into register in two cycles
// [RQ7] post-increment put writes source at pointer, then pointer plus one
// [RQ8] pre-decrement put lowers pointer first, then writes source there
// [RQ9] displaced put writes source at Y or Z plus displacement; pointer unchanged
// [RQ10] direct put writes source at immediate address in two cycles; no flags
// [RQ11] stack save puts source on stack in two cycles; no flags
// [RQ12] stack restore takes byte from stack into register in two cycles
// [RQ13] io bit set and clear force one io register bit, two cycles
// [RQ14] rotate left through carry; updates Z C N V in one cycle
// [RQ15] rotate right through carry; updates Z C N V in one cycle
// [RQ16] copy bit to T sets T from selected source bit; one cycle
// [RQ17] copy T to bit writes T into selected destination bit; one cycle
// [RQ18] overflow set and clear force V, one cycle, others untouched
// [RQ19] half-carry set and clear force H in one cycle
// [RQ20] sign set and clear force S in one cycle, others untouched
// [RQ21] sleep takes one cycle and leaves flags unchanged
// [RQ22] conditional jump takes one cycle when false, two when taken
// [RQ23] jump offset is signed words added to the following instruction's address
`timescale 1ns/10ps
`default_nettype none
module mcx_exec (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_op_valid,
  input  wire logic [4:0]  i_op,
  input  wire logic [4:0]  i_rd,
  input  wire logic [1:0]  i_ptr_sel,
  input  wire logic [1:0]  i_amode,
  input  wire logic [5:0]  i_disp,
  input  wire logic [15:0] i_imm,
  input  wire logic [2:0]  i_bit,
  input  wire logic [7:0]  i_mem_rdata,
  output logic             o_op_ready,
  output logic             o_mem_rd,
  output logic             o_mem_wr,
  output logic [15:0]      o_mem_addr,
  output logic [7:0]       o_mem_wdata,
  output logic             o_sleep,
  output logic [15:0]      o_pc,
  output logic [7:0]       o_flags,
  output logic [15:0]      o_sp
);
  mcx_pkg::mcx_state_e state_reg;
  mcx_pkg::mcx_state_e state_next;
  logic [7:0]  gpr_reg [32];
  logic [15:0] pc_reg;
  logic [7:0]  flags_reg;
  logic [15:0] sp_reg;
  logic [4:0]  op_reg;
  logic [4:0]  rd_reg;
  logic [15:0] addr_reg;
  logic [7:0]  wdata_reg;
  logic [2:0]  bit_reg;
  logic        rd_act_reg;
  logic        wr_act_reg;
  logic        sleep_reg;

  wire mcx_pkg::mcx_op_e op = mcx_pkg::mcx_op_e'(i_op);
  wire logic take = i_op_valid && state_reg == mcx_pkg::ST_FIRST;
  wire logic [4:0] ptr_lo = (i_ptr_sel == mcx_pkg::PTR_X) ? 5'h1A :
                            (i_ptr_sel == mcx_pkg::PTR_Y) ? 5'h1C : 5'h1E;
  wire logic [15:0] ptr = {gpr_reg[ptr_lo + 5'h01], gpr_reg[ptr_lo]};
  wire logic [15:0] ptr_dec = ptr - 16'h0001;
  wire logic [15:0] ptr_inc = ptr + 16'h0001;
  // displaced forms add i_disp to whichever pointer i_ptr_sel picks, X included
  wire logic [15:0] ptr_ofs = ptr + {10'h000, i_disp};
  wire logic [7:0] src = gpr_reg[i_rd];
  wire logic is_ind = op == mcx_pkg::OP_IND_LD || op == mcx_pkg::OP_IND_ST;
  wire logic ptr_upd = is_ind && i_amode != mcx_pkg::AM_PLAIN;
  wire logic [15:0] ptr_new = (i_amode == mcx_pkg::AM_PREDEC) ? ptr_dec : ptr_inc;
  wire logic [15:0] ind_addr = (i_amode == mcx_pkg::AM_PREDEC) ? ptr_dec : ptr; // RQ4 RQ8
  wire logic is_ld = op == mcx_pkg::OP_IND_LD || op == mcx_pkg::OP_OFS_LD ||
                     op == mcx_pkg::OP_DIR_LD || op == mcx_pkg::OP_POP;
  wire logic is_st = op == mcx_pkg::OP_IND_ST || op == mcx_pkg::OP_OFS_ST ||
                     op == mcx_pkg::OP_DIR_ST || op == mcx_pkg::OP_PUSH;
  wire logic is_io = op == mcx_pkg::OP_IOSET || op == mcx_pkg::OP_IOCLR;
  // io bit ops are read-modify-write over two cycles
  wire logic [15:0] mem_addr_first =
      (op == mcx_pkg::OP_OFS_LD || op == mcx_pkg::OP_OFS_ST) ? ptr_ofs :      // RQ5 RQ9
      (op == mcx_pkg::OP_DIR_LD || op == mcx_pkg::OP_DIR_ST) ? i_imm :        // RQ6 RQ10
      (op == mcx_pkg::OP_PUSH) ? sp_reg :                                     // RQ11
      (op == mcx_pkg::OP_POP) ? sp_reg + 16'h0001 :                           // RQ12
      is_io ? i_imm : ind_addr;                                               // RQ3 RQ7 RQ13
  wire logic v = flags_reg[mcx_pkg::FLAG_V];
  wire logic iflag = flags_reg[mcx_pkg::FLAG_I];
  wire logic jump_hit = (op == mcx_pkg::OP_JMP_V1 && v) || (op == mcx_pkg::OP_JMP_V0 && !v) ||
                        (op == mcx_pkg::OP_JMP_I1 && iflag) ||
                        (op == mcx_pkg::OP_JMP_I0 && !iflag); // RQ1 RQ2
  wire logic is_jmp = op == mcx_pkg::OP_JMP_V1 || op == mcx_pkg::OP_JMP_V0 ||
                      op == mcx_pkg::OP_JMP_I1 || op == mcx_pkg::OP_JMP_I0;
  // offset taken from i_imm low seven bits as signed words
  wire logic [15:0] jump_tgt = pc_reg + 16'h0001 + {{9{i_imm[6]}}, i_imm[6:0]}; // RQ23
  wire logic two_cycle = is_ld || is_st || is_io || jump_hit; // RQ22
  wire logic [7:0] rol_v = {src[6:0], flags_reg[mcx_pkg::FLAG_C]};
  wire logic [7:0] ror_v = {flags_reg[mcx_pkg::FLAG_C], src[7:1]};
  wire logic [7:0] rot_v = (op == mcx_pkg::OP_ROL) ? rol_v : ror_v;
  wire logic rot_c = (op == mcx_pkg::OP_ROL) ? src[7] : src[0];
  wire logic [7:0] io_v = (op_reg == mcx_pkg::OP_IOSET) ?
                          (i_mem_rdata | (8'h01 << bit_reg)) :
                          (i_mem_rdata & ~(8'h01 << bit_reg));

  assign state_next = (state_reg == mcx_pkg::ST_SECOND) ? mcx_pkg::ST_FIRST :
                      (take && two_cycle) ? mcx_pkg::ST_SECOND : mcx_pkg::ST_FIRST;
  assign o_op_ready = state_reg == mcx_pkg::ST_FIRST;
  assign o_mem_rd = rd_act_reg;
  assign o_mem_wr = wr_act_reg;
  assign o_mem_addr = addr_reg;
  assign o_mem_wdata = wdata_reg;
  assign o_sleep = sleep_reg;
  assign o_pc = pc_reg;
  assign o_flags = flags_reg;
  assign o_sp = sp_reg;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= mcx_pkg::ST_FIRST;
    end else begin
      state_reg <= state_next;
    end
  end

  // first cycle: decode, issue memory access, one-cycle ops complete
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pc_reg     <= mcx_pkg::PC_RESET;
      flags_reg  <= mcx_pkg::FLAGS_RESET;
      sp_reg     <= mcx_pkg::SP_RESET;
      op_reg     <= 5'h00;
      rd_reg     <= 5'h00;
      addr_reg   <= 16'h0000;
      wdata_reg  <= 8'h00;
      bit_reg    <= 3'h0;
      rd_act_reg <= 1'b0;
      wr_act_reg <= 1'b0;
      sleep_reg  <= 1'b0;
    end else if (take) begin
      op_reg     <= i_op;
      rd_reg     <= i_rd;
      bit_reg    <= i_bit;
      addr_reg   <= mem_addr_first;
      wdata_reg  <= src;
      rd_act_reg <= is_ld || is_io;
      wr_act_reg <= is_st;
      sleep_reg  <= op == mcx_pkg::OP_SLEEP; // RQ21
      pc_reg     <= jump_hit ? jump_tgt : pc_reg + 16'h0001; // RQ1 RQ2
      if (op == mcx_pkg::OP_PUSH) begin
        sp_reg <= sp_reg - 16'h0001; // RQ11
      end else if (op == mcx_pkg::OP_POP) begin
        sp_reg <= sp_reg + 16'h0001; // RQ12
      end
      unique case (op)
        mcx_pkg::OP_ROL, mcx_pkg::OP_ROR: begin
          flags_reg[mcx_pkg::FLAG_C] <= rot_c; // RQ14 RQ15
          flags_reg[mcx_pkg::FLAG_Z] <= rot_v == 8'h00;
          flags_reg[mcx_pkg::FLAG_N] <= rot_v[7];
          flags_reg[mcx_pkg::FLAG_V] <= rot_v[7] ^ rot_c;
        end
        mcx_pkg::OP_TSTORE: flags_reg[mcx_pkg::FLAG_T] <= src[i_bit]; // RQ16
        mcx_pkg::OP_SETV: flags_reg[mcx_pkg::FLAG_V] <= 1'b1; // RQ18
        mcx_pkg::OP_CLRV: flags_reg[mcx_pkg::FLAG_V] <= 1'b0; // RQ18
        mcx_pkg::OP_SETH: flags_reg[mcx_pkg::FLAG_H] <= 1'b1; // RQ19
        mcx_pkg::OP_CLRH: flags_reg[mcx_pkg::FLAG_H] <= 1'b0; // RQ19
        mcx_pkg::OP_SETS: flags_reg[mcx_pkg::FLAG_S] <= 1'b1; // RQ20
        mcx_pkg::OP_CLRS: flags_reg[mcx_pkg::FLAG_S] <= 1'b0; // RQ20
        default: flags_reg <= flags_reg;
      endcase
    end else if (state_reg == mcx_pkg::ST_SECOND) begin
      // second cycle: io ops write back the modified byte
      rd_act_reg <= 1'b0;
      wr_act_reg <= op_reg == mcx_pkg::OP_IOSET || op_reg == mcx_pkg::OP_IOCLR; // RQ13
      wdata_reg  <= io_v;
      sleep_reg  <= 1'b0;
    end else begin
      rd_act_reg <= 1'b0;
      wr_act_reg <= 1'b0;
      sleep_reg  <= 1'b0;
    end
  end

  // register file: pointer updates on issue, load data on second cycle
  logic [4:0] ptr_lo_reg;
  logic       ptr_wr_reg;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ptr_lo_reg <= 5'h00;
      ptr_wr_reg <= 1'b0;
    end else begin
      ptr_lo_reg <= ptr_lo;
      ptr_wr_reg <= take && ptr_upd;
    end
  end
  // pointer pair as it stands one cycle after issue, watched by the pointer checks
  wire logic [15:0] ptr_after = {gpr_reg[ptr_lo_reg + 5'h01], gpr_reg[ptr_lo_reg]};

  for (genvar g = 0; g < 32; g++) begin : g_gpr
    always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
        gpr_reg[g] <= 8'h00;
      end else if (take && ptr_upd && 5'(g) == ptr_lo) begin
        gpr_reg[g] <= ptr_new[7:0]; // RQ3 RQ4 RQ7 RQ8
      end else if (take && ptr_upd && 5'(g) == ptr_lo + 5'h01) begin
        gpr_reg[g] <= ptr_new[15:8];
      end else if (take && op == mcx_pkg::OP_ROL && 5'(g) == i_rd) begin
        gpr_reg[g] <= rol_v; // RQ14
      end else if (take && op == mcx_pkg::OP_ROR && 5'(g) == i_rd) begin
        gpr_reg[g] <= ror_v; // RQ15
      end else if (take && op == mcx_pkg::OP_TLOAD && 5'(g) == i_rd) begin
        gpr_reg[g][i_bit] <= flags_reg[mcx_pkg::FLAG_T]; // RQ17
      end else if (state_reg == mcx_pkg::ST_SECOND && rd_act_reg && 5'(g) == rd_reg &&
                   !(op_reg == mcx_pkg::OP_IOSET || op_reg == mcx_pkg::OP_IOCLR)) begin
        gpr_reg[g] <= i_mem_rdata; // RQ3 RQ4 RQ5 RQ6 RQ12
      end
    end
  end

  a_jump_two_cycles: assert property (@(posedge i_core_clk) disable iff (i_rst) // RQ22
    take && jump_hit |=> state_reg == mcx_pkg::ST_SECOND ##1 o_op_ready)
    else $error("taken jump did not last two cycles");
  a_jump_target: assert property (@(posedge i_core_clk) disable iff (i_rst) // RQ1
    take && jump_hit |=> o_pc == $past(jump_tgt) && o_flags == $past(o_flags))
    else $error("jump target or flags wrong");
  a_put_addr: assert property (@(posedge i_core_clk) disable iff (i_rst) // RQ9
    take && op == mcx_pkg::OP_OFS_ST |=> o_mem_wr && o_mem_addr == $past(ptr_ofs))
    else $error("displaced put address wrong");
  a_predec_fetch: assert property (@(posedge i_core_clk) disable iff (i_rst) // RQ4
    take && op == mcx_pkg::OP_IND_LD && i_amode == mcx_pkg::AM_PREDEC
    |=> o_mem_rd && o_mem_addr == $past(ptr) - 16'h0001)
    else $error("pre-decrement fetch address wrong");
  a_push_sp: assert property (@(posedge i_core_clk) disable iff (i_rst) // RQ11
    take && op == mcx_pkg::OP_PUSH |=> o_sp == $past(o_sp) - 16'h0001 && o_mem_wr)
    else $error("push stack pointer wrong");
  a_rol_carry: assert property (@(posedge i_core_clk) disable iff (i_rst) // RQ14
    take && op == mcx_pkg::OP_ROL |=> o_flags[mcx_pkg::FLAG_C] == $past(src[7]))
    else $error("rotate left carry wrong");
  a_setv_only: assert property (@(posedge i_core_clk) disable iff (i_rst) // RQ18
    take && op == mcx_pkg::OP_SETV |=> o_flags == ($past(o_flags) | 8'h08))
    else $error("overflow set touched other flags");
  a_sleep_pulse: assert property (@(posedge i_core_clk) disable iff (i_rst) // RQ21
    take && op == mcx_pkg::OP_SLEEP |=> o_sleep && o_op_ready && o_flags == $past(o_flags))
    else $error("sleep wrong");
  a_io_write: assert property (@(posedge i_core_clk) disable iff (i_rst) // RQ13
    take && is_io |=> o_mem_rd ##1 o_mem_wr && o_op_ready)
    else $error("io bit op sequence wrong");
  a_postinc_fetch: assert property (@(posedge i_core_clk) disable iff (i_rst) // RQ3
    take && op == mcx_pkg::OP_IND_LD && i_amode == mcx_pkg::AM_POSTINC
    |=> o_mem_rd && o_mem_addr == $past(ptr) && ptr_wr_reg &&
        ptr_after == $past(ptr) + 16'h0001)
    else $error("post-increment fetch address or pointer wrong");
  a_postinc_put: assert property (@(posedge i_core_clk) disable iff (i_rst) // RQ7
    take && op == mcx_pkg::OP_IND_ST && i_amode == mcx_pkg::AM_POSTINC
    |=> o_mem_wr && o_mem_addr == $past(ptr) && o_mem_wdata == $past(src) &&
        ptr_after == $past(ptr) + 16'h0001)
    else $error("post-increment put address or pointer wrong");
  a_predec_put: assert property (@(posedge i_core_clk) disable iff (i_rst) // RQ8
    take && op == mcx_pkg::OP_IND_ST && i_amode == mcx_pkg::AM_PREDEC
    |=> o_mem_wr && o_mem_addr == $past(ptr) - 16'h0001 && ptr_wr_reg &&
        ptr_after == $past(ptr) - 16'h0001)
    else $error("pre-decrement put address or pointer wrong");
  a_disp_fetch: assert property (@(posedge i_core_clk) disable iff (i_rst) // RQ5
    take && op == mcx_pkg::OP_OFS_LD
    |=> o_mem_rd && o_mem_addr == $past(ptr) + {10'h000, $past(i_disp)} &&
        ptr_after == $past(ptr))
    else $error("displaced fetch address or pointer wrong");
  a_direct_fetch: assert property (@(posedge i_core_clk) disable iff (i_rst) // RQ6
    take && op == mcx_pkg::OP_DIR_LD |=> o_mem_rd && o_mem_addr == $past(i_imm)
    ##1 o_op_ready && gpr_reg[rd_reg] == $past(i_mem_rdata) && o_flags == $past(o_flags, 2))
    else $error("direct fetch wrong");
  a_pop_fetch: assert property (@(posedge i_core_clk) disable iff (i_rst) // RQ12
    take && op == mcx_pkg::OP_POP
    |=> o_mem_rd && o_sp == $past(o_sp) + 16'h0001 && o_mem_addr == o_sp
    ##1 gpr_reg[rd_reg] == $past(i_mem_rdata) && o_flags == $past(o_flags, 2))
    else $error("stack restore wrong");
  a_direct_put: assert property (@(posedge i_core_clk) disable iff (i_rst) // RQ10
    take && op == mcx_pkg::OP_DIR_ST
    |=> o_mem_wr && o_mem_addr == $past(i_imm) && o_mem_wdata == $past(src) &&
        o_flags == $past(o_flags))
    else $error("direct put wrong");
  a_ror_carry: assert property (@(posedge i_core_clk) disable iff (i_rst) // RQ15
    take && op == mcx_pkg::OP_ROR
    |=> o_flags[mcx_pkg::FLAG_C] == $past(src[0]) &&
        gpr_reg[rd_reg][7] == $past(o_flags[mcx_pkg::FLAG_C]))
    else $error("rotate right carry wrong");
  a_tflag_copy: assert property (@(posedge i_core_clk) disable iff (i_rst) // RQ16
    take && op == mcx_pkg::OP_TSTORE
    |=> o_flags[mcx_pkg::FLAG_T] == $past(src[i_bit]) &&
        (o_flags & 8'hBF) == ($past(o_flags) & 8'hBF))
    else $error("copy to T wrong");
  a_tflag_load: assert property (@(posedge i_core_clk) disable iff (i_rst) // RQ17
    take && op == mcx_pkg::OP_TLOAD
    |=> gpr_reg[rd_reg][bit_reg] == $past(o_flags[mcx_pkg::FLAG_T]) &&
        o_flags == $past(o_flags))
    else $error("copy from T wrong");
  a_clrv_only: assert property (@(posedge i_core_clk) disable iff (i_rst) // RQ18
    take && op == mcx_pkg::OP_CLRV |=> o_flags == ($past(o_flags) & 8'hF7))
    else $error("overflow clear touched other flags");
  a_seth_only: assert property (@(posedge i_core_clk) disable iff (i_rst) // RQ19
    take && op == mcx_pkg::OP_SETH |=> o_flags == ($past(o_flags) | 8'h20))
    else $error("half-carry set touched other flags");
  a_clrh_only: assert property (@(posedge i_core_clk) disable iff (i_rst) // RQ19
    take && op == mcx_pkg::OP_CLRH |=> o_flags == ($past(o_flags) & 8'hDF))
    else $error("half-carry clear touched other flags");
  a_sets_only: assert property (@(posedge i_core_clk) disable iff (i_rst) // RQ20
    take && op == mcx_pkg::OP_SETS |=> o_flags == ($past(o_flags) | 8'h10))
    else $error("sign set touched other flags");
  a_clrs_only: assert property (@(posedge i_core_clk) disable iff (i_rst) // RQ20
    take && op == mcx_pkg::OP_CLRS |=> o_flags == ($past(o_flags) & 8'hEF))
    else $error("sign clear touched other flags");
  a_jump_skip: assert property (@(posedge i_core_clk) disable iff (i_rst) // RQ22
    take && is_jmp && !jump_hit |=> o_op_ready && o_pc == $past(o_pc) + 16'h0001)
    else $error("untaken jump wrong");
  a_jump_offset: assert property (@(posedge i_core_clk) disable iff (i_rst) // RQ23
    take && jump_hit
    |=> o_pc == $past(o_pc) + 16'h0001 + {{9{$past(i_imm[6])}}, $past(i_imm[6:0])})
    else $error("jump offset wrong");
  a_irq_off_jump: assert property (@(posedge i_core_clk) disable iff (i_rst) // RQ2
    take && op == mcx_pkg::OP_JMP_I0 && !iflag |=> !o_op_ready && o_flags == $past(o_flags))
    else $error("interrupt-off jump wrong");
  a_io_set_data: assert property (@(posedge i_core_clk) disable iff (i_rst) // RQ13
    take && op == mcx_pkg::OP_IOSET
    |=> o_mem_rd ##1 o_mem_wr && o_mem_addr == $past(i_imm, 2) &&
        o_mem_wdata == ($past(i_mem_rdata) | (8'h01 << $past(i_bit, 2))))
    else $error("io bit set data wrong");
endmodule
`default_nettype wire

// file: src/mcx_pkg.sv
// constants for the instruction-subset execution unit
package mcx_pkg;
  // status flag bit positions
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_T = 6;
  localparam int unsigned FLAG_I = 7;
  localparam logic [7:0]  FLAGS_RESET = 8'h00;
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [15:0] SP_RESET    = 16'h00DF;
  localparam logic [15:0] PTR_RESET   = 16'h0000;
  // pointer select codes
  localparam logic [1:0] PTR_X = 2'h0;
  localparam logic [1:0] PTR_Y = 2'h1;
  localparam logic [1:0] PTR_Z = 2'h2;
  // pointer addressing modes
  localparam logic [1:0] AM_PLAIN = 2'h0;
  localparam logic [1:0] AM_POSTINC = 2'h1;
  localparam logic [1:0] AM_PREDEC = 2'h2;
  // operation codes presented on i_op
  typedef enum logic [4:0] {
    OP_NOP      = 5'h00,
    OP_JMP_V1   = 5'h01,
    OP_JMP_V0   = 5'h02,
    OP_JMP_I1   = 5'h03,
    OP_JMP_I0   = 5'h04,
    OP_IND_LD   = 5'h05,
    OP_OFS_LD   = 5'h06,
    OP_DIR_LD   = 5'h07,
    OP_IND_ST   = 5'h08,
    OP_OFS_ST   = 5'h09,
    OP_DIR_ST   = 5'h0A,
    OP_PUSH     = 5'h0B,
    OP_POP      = 5'h0C,
    OP_IOSET    = 5'h0D,
    OP_IOCLR    = 5'h0E,
    OP_ROL      = 5'h0F,
    OP_ROR      = 5'h10,
    OP_TSTORE   = 5'h11,
    OP_TLOAD    = 5'h12,
    OP_SETV     = 5'h13,
    OP_CLRV     = 5'h14,
    OP_SETH     = 5'h15,
    OP_CLRH     = 5'h16,
    OP_SETS     = 5'h17,
    OP_CLRS     = 5'h18,
    OP_SLEEP    = 5'h19
  } mcx_op_e;
  // execution phases
  typedef enum logic [1:0] {
    ST_FIRST  = 2'b01,
    ST_SECOND = 2'b10
  } mcx_state_e;
endpackage
